/* include/grfc_pkg.sv */
package grfc_pkg;
  localparam int unsigned PCLK_PERIOD_NS = 100;
  localparam int unsigned BASE_PERIOD_US = 1000;
  // 1 kHz base rate expressed in pclk cycles
  localparam int unsigned BASE_CYC =
    (BASE_PERIOD_US * 1000) / PCLK_PERIOD_NS;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;
  localparam int unsigned SMP_W  = 16;
  localparam logic [IDX_W-1:0] IDX_TRIM_HI = 10'h017;
  localparam logic [IDX_W-1:0] IDX_TRIM_LO = 10'h018;
  localparam logic [IDX_W-1:0] IDX_DIV     = 10'h019;
  localparam logic [IDX_W-1:0] IDX_CFG     = 10'h01A;
  localparam logic [IDX_W-1:0] IDX_ZOUT    = 10'h020;
  localparam logic [IDX_W-1:0] IDX_QDATA   = 10'h021;
  localparam logic [IDX_W-1:0] IDX_QSTAT   = 10'h022;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int unsigned CFG_REC_BIT  = 7;
  localparam int unsigned CFG_MODE_BIT = 6;
  localparam int unsigned CFG_SYNC_HI  = 5;
  localparam int unsigned CFG_SYNC_LO  = 3;
  localparam int unsigned CFG_LPF_HI   = 2;
  localparam int unsigned CFG_LPF_LO   = 0;
  localparam logic [2:0] LPF_MAX = 3'h7;
  localparam logic [2:0] LPF_MIN = 3'h0;
  localparam int unsigned QSTAT_FULL_BIT  = 16;
  localparam int unsigned QSTAT_EMPTY_BIT = 17;
  // bypass select value for filter choice, held locally
  localparam logic [1:0] BYP_NONE = 2'h0;
  localparam logic [1:0] BYP_MID  = 2'h2;
  // sync tag slots
  localparam logic [2:0] TAG_OFF  = 3'h0;
  localparam logic [2:0] TAG_TEMP = 3'h1;
  localparam logic [2:0] TAG_XR   = 3'h2;
  localparam logic [2:0] TAG_YR   = 3'h3;
  localparam logic [2:0] TAG_ZR   = 3'h4;
  localparam logic [2:0] TAG_XA   = 3'h5;
  localparam logic [2:0] TAG_YA   = 3'h6;
  localparam logic [2:0] TAG_ZA   = 3'h7;
  typedef enum logic [1:0] {grfc_idle_t_x} grfc_unused_t;
endpackage

/* include/grfc_queue_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface grfc_queue_if #(parameter int unsigned W = 16,
                          parameter int unsigned CW = 5);
  logic          push;
  logic [W-1:0]  wdata;
  logic          pop;
  logic [W-1:0]  rdata;
  logic [CW-1:0] count;
  logic          full;
  logic          empty;
  logic          keep_on_full;
  modport owner (output push, wdata, pop, keep_on_full,
                 input rdata, count, full, empty);
  modport fifo  (input push, wdata, pop, keep_on_full,
                 output rdata, count, full, empty);
endinterface
`default_nettype wire

/* logic/grfc_rate_div.sv */
`timescale 1ns/1ps
`default_nettype none
module grfc_rate_div #(
  parameter int unsigned BASE_CYC = grfc_pkg::BASE_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] div,
  input  wire logic       div_en,
  output logic            base_tick,
  output logic            sample_tick
);
  logic [31:0] pre_q;
  logic [7:0]  cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q     <= 32'h0;
      base_tick <= 1'b0;
    end else if (pre_q == 32'(BASE_CYC - 1)) begin
      pre_q     <= 32'h0;
      base_tick <= 1'b1;
    end else begin
      pre_q     <= pre_q + 32'h1;
      base_tick <= 1'b0;
    end
  end

  // [RQ3] divide by one plus divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q       <= 8'h00;
      sample_tick <= 1'b0;
    end else if (base_tick) begin
      // [RQ5] divider ignored unless enabled
      if (!div_en || cnt_q >= div) begin
        cnt_q       <= 8'h00;
        sample_tick <= 1'b1;
      end else begin
        cnt_q       <= cnt_q + 8'h01;
        sample_tick <= 1'b0;
      end
    end else begin
      sample_tick <= 1'b0;
    end
  end
endmodule // grfc_rate_div
`default_nettype wire

/* logic/grfc_queue.sv */
`timescale 1ns/1ps
`default_nettype none
module grfc_queue #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  grfc_queue_if.fifo q
);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          do_pop;
  logic          do_push;
  logic          overwrite;

  assign do_pop    = q.pop && (cnt_q != '0);
  // [RQ6] full queue drops new sample
  assign do_push   = q.push && (!q.full || !q.keep_on_full || do_pop);
  // [RQ7] full queue overwrites oldest entry
  assign overwrite = do_push && q.full && !do_pop;

  assign q.full  = (cnt_q == (AW+1)'(DEPTH));
  assign q.empty = (cnt_q == '0);
  assign q.rdata = mem_q[rd_q];
  assign q.count = cnt_q;

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem_q[wr_q] <= q.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (do_pop || overwrite) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      if (do_push && !do_pop && !overwrite) begin
        cnt_q <= cnt_q + (AW+1)'(1);
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - (AW+1)'(1);
      end
    end
  end
endmodule // grfc_queue
`default_nettype wire

/* logic/grfc_top.sv */
// Notes on behaviour
// [RQ1] z trim: 16-bit two's complement, two bytes
// [RQ2] trim added to raw z before output
// [RQ3] rate equals 1 kHz over divider+1
// [RQ4] divided rate paces outputs and queue
// [RQ5] divider only with no bypass, lpf 1..6
// [RQ6] policy one: full queue drops samples
// [RQ7] policy zero: full queue overwrites oldest
// [RQ8] lpf setting used only without bypass
// [RQ9] bypass bits and setting pick bandwidth
// [RQ10] sync code tags chosen low bit
// [RQ11] software writes zero to count-record bit
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module grfc_top #(
  parameter int unsigned BASE_CYC = grfc_pkg::BASE_CYC,
  parameter int unsigned QDEPTH   = 16,
  parameter int unsigned QAW      = 4
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [grfc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [1:0]                  filter_bypass,
  input  wire logic                        frame_sync_input,
  input  wire logic [15:0]                 raw_temp,
  input  wire logic [15:0]                 raw_x_rate,
  input  wire logic [15:0]                 raw_y_rate,
  input  wire logic [15:0]                 raw_z_rate,
  input  wire logic [15:0]                 raw_x_accel,
  input  wire logic [15:0]                 raw_y_accel,
  input  wire logic [15:0]                 raw_z_accel,
  output logic [15:0]                      temp_out,
  output logic [15:0]                      x_rate_out,
  output logic [15:0]                      y_rate_out,
  output logic [15:0]                      z_rate_out,
  output logic [15:0]                      x_accel_out,
  output logic [15:0]                      y_accel_out,
  output logic [15:0]                      z_accel_out,
  output logic                             sample_strobe
);
  localparam int unsigned SW = grfc_pkg::SMP_W;

  // right-shift amount of the low-pass; zero means no smoothing
  function automatic logic [2:0] lpf_shift(input logic [1:0] byp,
                                           input logic [2:0] cfg);
    // [RQ9] bypass picks widest paths
    if (byp[0]) begin
      lpf_shift = 3'h0;
    end else if (byp == grfc_pkg::BYP_MID) begin
      lpf_shift = 3'h0;
    end else if (cfg == grfc_pkg::LPF_MAX) begin
      lpf_shift = 3'h0;
    end else begin
      // [RQ8] setting used only without bypass
      lpf_shift = cfg + 3'h1;
    end
  endfunction

  // first-order smoothing, wider internally to avoid wrap
  function automatic logic [SW-1:0] iir(input logic [SW-1:0] y,
                                        input logic [SW-1:0] x,
                                        input logic [2:0]    k);
    logic signed [SW:0] diff;
    logic signed [SW:0] sum;
    diff = $signed({x[SW-1], x}) - $signed({y[SW-1], y});
    sum  = $signed({y[SW-1], y}) + (diff >>> k);
    iir  = sum[SW-1:0];
  endfunction

  // saturating signed add keeps bias trim from wrapping
  function automatic logic [SW-1:0] sat_add(input logic [SW-1:0] a,
                                            input logic [SW-1:0] b);
    logic signed [SW:0] s;
    s = $signed({a[SW-1], a}) + $signed({b[SW-1], b});
    if (s[SW] != s[SW-1]) begin
      sat_add = s[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
    end else begin
      sat_add = s[SW-1:0];
    end
  endfunction

  function automatic logic [SW-1:0] tag(input logic [SW-1:0] v,
                                        input logic [2:0]    code,
                                        input logic [2:0]    slot,
                                        input logic          lvl);
    tag = v;
    if (code != grfc_pkg::TAG_OFF && code == slot) begin
      tag[0] = lvl;
    end
  endfunction

  logic [7:0]  trim_hi_q;
  logic [7:0]  trim_lo_q;
  logic [7:0]  div_q;
  logic [7:0]  cfg_q;
  logic        sync1_q;
  logic        sync2_q;
  logic [SW-1:0] f_temp_q;
  logic [SW-1:0] f_x_q;
  logic [SW-1:0] f_y_q;
  logic [SW-1:0] f_z_q;
  logic [31:0] rd_d;
  logic        err_d;
  logic        base_tick;
  logic        sample_tick;
  logic        div_en;
  logic [2:0]  lpf;
  logic [2:0]  sync_code;
  logic [2:0]  shift;
  logic [SW-1:0] z_trim;
  logic [SW-1:0] z_trimmed;
  logic [grfc_pkg::IDX_W-1:0] idx;
  logic        setup;
  logic        wr_done;
  logic        rd_done;

  grfc_queue_if #(.W(SW), .CW(QAW + 1)) qif ();

  assign lpf       = cfg_q[grfc_pkg::CFG_LPF_HI:grfc_pkg::CFG_LPF_LO];
  assign sync_code = cfg_q[grfc_pkg::CFG_SYNC_HI:grfc_pkg::CFG_SYNC_LO];
  assign shift     = lpf_shift(filter_bypass, lpf);
  // [RQ1] trim assembled from two bytes
  assign z_trim    = {trim_hi_q, trim_lo_q};
  // [RQ2] trim added to raw z sample
  assign z_trimmed = sat_add(raw_z_rate, z_trim);
  // [RQ5] divider gated by bypass and setting
  assign div_en    = (filter_bypass == grfc_pkg::BYP_NONE) &&
                     (lpf > grfc_pkg::LPF_MIN) &&
                     (lpf < grfc_pkg::LPF_MAX);

  assign idx     = paddr[grfc_pkg::ADDR_W-1:2];
  assign setup   = psel && !penable;
  assign wr_done = psel && penable && pready && pwrite && !pslverr;
  assign rd_done = psel && penable && pready && !pwrite && !pslverr;

  grfc_rate_div #(.BASE_CYC(BASE_CYC)) u_div (
    .pclk        (pclk),
    .presetn     (presetn),
    .div         (div_q),
    .div_en      (div_en),
    .base_tick   (base_tick),
    .sample_tick (sample_tick)
  );

  grfc_queue #(.W(SW), .DEPTH(QDEPTH), .AW(QAW)) u_queue (
    .pclk    (pclk),
    .presetn (presetn),
    .q       (qif.fifo)
  );

  // [RQ4] queue written at divided rate
  assign qif.push         = sample_tick;
  assign qif.wdata        = tag(f_z_q, sync_code, grfc_pkg::TAG_ZR,
                                sync2_q);
  assign qif.pop          = rd_done && (idx == grfc_pkg::IDX_QDATA);
  // [RQ6] policy bit selects drop on full
  assign qif.keep_on_full = cfg_q[grfc_pkg::CFG_MODE_BIT];

  // sync pin is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= frame_sync_input;
      sync2_q <= sync1_q;
    end
  end

  // register writes land on the completing access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_hi_q <= grfc_pkg::REG_RST;
      trim_lo_q <= grfc_pkg::REG_RST;
      div_q     <= grfc_pkg::REG_RST;
      cfg_q     <= grfc_pkg::REG_RST;
    end else if (wr_done && pstrb[0]) begin
      case (idx)
        // [RQ1] upper and lower trim bytes
        grfc_pkg::IDX_TRIM_HI: trim_hi_q <= pwdata[7:0];
        grfc_pkg::IDX_TRIM_LO: trim_lo_q <= pwdata[7:0];
        // [RQ3] divider value stored
        grfc_pkg::IDX_DIV:     div_q     <= pwdata[7:0];
        // [RQ11] record bit stored, has no effect
        grfc_pkg::IDX_CFG:     cfg_q     <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_d  = 32'h0;
    err_d = 1'b0;
    case (idx)
      grfc_pkg::IDX_TRIM_HI: rd_d[7:0] = trim_hi_q;
      grfc_pkg::IDX_TRIM_LO: rd_d[7:0] = trim_lo_q;
      grfc_pkg::IDX_DIV:     rd_d[7:0] = div_q;
      grfc_pkg::IDX_CFG:     rd_d[7:0] = cfg_q;
      grfc_pkg::IDX_ZOUT:    rd_d[SW-1:0] = z_rate_out;
      grfc_pkg::IDX_QDATA:   rd_d[SW-1:0] = qif.rdata;
      grfc_pkg::IDX_QSTAT: begin
        rd_d[QAW:0] = qif.count;
        rd_d[grfc_pkg::QSTAT_FULL_BIT]  = qif.full;
        rd_d[grfc_pkg::QSTAT_EMPTY_BIT] = qif.empty;
      end
      default: err_d = 1'b1;
    endcase
    if (paddr[1:0] != 2'h0) begin
      err_d = 1'b1;
    end
  end

  // answer is prepared in setup, so the access phase has no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup && err_d;
      // a refused access of either direction answers with zero data
      if (setup && (!pwrite || err_d)) begin
        prdata <= err_d ? 32'h0 : rd_d;
      end
    end
  end

  // smoothing runs at the base rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_temp_q <= '0;
      f_x_q    <= '0;
      f_y_q    <= '0;
      f_z_q    <= '0;
    end else if (base_tick) begin
      // [RQ9] same bandwidth for rate and temperature
      f_temp_q <= iir(f_temp_q, raw_temp, shift);
      f_x_q    <= iir(f_x_q, raw_x_rate, shift);
      f_y_q    <= iir(f_y_q, raw_y_rate, shift);
      f_z_q    <= iir(f_z_q, z_trimmed, shift);
    end
  end

  // [RQ4] outputs refresh at divided rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_out      <= '0;
      x_rate_out    <= '0;
      y_rate_out    <= '0;
      z_rate_out    <= '0;
      x_accel_out   <= '0;
      y_accel_out   <= '0;
      z_accel_out   <= '0;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= sample_tick;
      if (sample_tick) begin
        // [RQ10] sync level tags selected low bit
        temp_out    <= tag(f_temp_q, sync_code, grfc_pkg::TAG_TEMP,
                           sync2_q);
        x_rate_out  <= tag(f_x_q, sync_code, grfc_pkg::TAG_XR, sync2_q);
        y_rate_out  <= tag(f_y_q, sync_code, grfc_pkg::TAG_YR, sync2_q);
        z_rate_out  <= tag(f_z_q, sync_code, grfc_pkg::TAG_ZR, sync2_q);
        x_accel_out <= tag(raw_x_accel, sync_code, grfc_pkg::TAG_XA,
                           sync2_q);
        y_accel_out <= tag(raw_y_accel, sync_code, grfc_pkg::TAG_YA,
                           sync2_q);
        z_accel_out <= tag(raw_z_accel, sync_code, grfc_pkg::TAG_ZA,
                           sync2_q);
      end
    end
  end
endmodule // grfc_top
`default_nettype wire

/* tb/grfc_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module grfc_top_checker #(
  parameter int unsigned BASE_CYC = grfc_pkg::BASE_CYC
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic [grfc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [15:0]                 z_rate_out,
  input wire logic                        sample_strobe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // cycles since the last strobe, parked at max after reset
  logic [15:0] gap_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_q <= 16'hFFFF;
    else if (sample_strobe) gap_q <= 16'h0001;
    else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
  end

  property p_ready_after_setup; psel && !penable |=> pready; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready missing after setup");
  property p_ready_single; pready |=> !pready; endproperty
  a_ready_single: assert property (p_ready_single)
    else $error("pready longer than one cycle");
  property p_ready_cause; !(psel && !penable) |=> !pready; endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without setup");
  property p_err_shape; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_shape: assert property (p_err_shape)
    else $error("error response malformed");
  property p_misaligned;
    psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
  endproperty
  a_misaligned: assert property (p_misaligned)
    else $error("misaligned access not refused");
  property p_strobe_pulse; sample_strobe |=> !sample_strobe; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("sample strobe wider than one cycle");
  property p_out_on_strobe; $changed(z_rate_out[15:1]) |-> sample_strobe;
  endproperty
  a_out_on_strobe: assert property (p_out_on_strobe)
    else $error("z output moved without strobe");
  property p_strobe_gap; sample_strobe |-> gap_q >= BASE_CYC; endproperty
  a_strobe_gap: assert property (p_strobe_gap)
    else $error("strobes closer than base period");
  cover property (sample_strobe && gap_q > 16'(2 * BASE_CYC));
endmodule // grfc_top_checker

bind grfc_top grfc_top_checker #(.BASE_CYC(BASE_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .z_rate_out(z_rate_out), .sample_strobe(sample_strobe));
`default_nettype wire

/* tb/grfc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module grfc_top_tb_top;
  localparam int unsigned BC = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        frame_sync_input, sample_strobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [1:0]  filter_bypass;
  logic [15:0] raw [7];
  logic [15:0] outs [7];
  int          err_count, check_count;
  logic [1:0]  db [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  logic [2:0]  dl [7] = '{3'h3, 3'h1, 3'h6, 3'h0, 3'h7, 3'h3, 3'h3};
  logic [7:0]  dd [7] = '{8'h02, 8'h00, 8'h04, 8'h02, 8'h02, 8'h02, 8'h02};
  int          dm [7] = '{3, 1, 5, 1, 1, 1, 1};

  grfc_top #(.BASE_CYC(BC), .QDEPTH(4), .QAW(2)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filter_bypass(filter_bypass), .frame_sync_input(frame_sync_input),
    .raw_temp(raw[0]), .raw_x_rate(raw[1]), .raw_y_rate(raw[2]),
    .raw_z_rate(raw[3]), .raw_x_accel(raw[4]), .raw_y_accel(raw[5]),
    .raw_z_accel(raw[6]), .temp_out(outs[0]), .x_rate_out(outs[1]),
    .y_rate_out(outs[2]), .z_rate_out(outs[3]), .x_accel_out(outs[4]),
    .y_accel_out(outs[5]), .z_accel_out(outs[6]),
    .sample_strobe(sample_strobe));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic test_done();
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic timeout(input string nm);
    $display("BAD %s expected done seen timeout", nm);
    err_count++;
    test_done();
  endtask

  // request held from setup until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [1:0] lo, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, lo};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timeout("pready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, idx, 2'h0, d, q, e);
  endtask

  task automatic rdc(input string nm, input logic [9:0] idx,
                     input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, idx, 2'h0, 32'h0, q, e);
    chk(nm, x, q);
  endtask

  // strobe seen at an edge means outputs are readable right then
  task automatic wstb(input int k, output int n);
    repeat (k) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (sample_strobe !== 1'b1 && n < 2000);
      if (n >= 2000) timeout("strobe");
    end
  endtask

  function automatic logic [15:0] sat(input logic [15:0] a, b);
    logic signed [16:0] s;
    s = $signed({a[15], a}) + $signed({b[15], b});
    if (s > 17'sd32767) return 16'h7FFF;
    if (s < -17'sd32768) return 16'h8000;
    return s[15:0];
  endfunction

  initial begin
    repeat (100000) @(posedge pclk);
    timeout("run");
  end

  initial begin
    int          i, n, p;
    logic [15:0] tr, rz;
    logic [31:0] q;
    logic        e;
    err_count = 0;
    check_count = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    filter_bypass = 2'h1;
    frame_sync_input = 1'b0;
    presetn = 1'b0;
    void'($urandom(32'hF554D4EB));
    foreach (raw[k]) raw[k] = 16'($urandom) & 16'hFFFE;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rdc("reset value", grfc_pkg::IDX_TRIM_HI + 10'(i), 32'h0);
      q = $urandom & 32'hFF;
      if (i == 3) q[7] = 1'b0;
      wr(grfc_pkg::IDX_TRIM_HI + 10'(i), q);
      rdc("readback", grfc_pkg::IDX_TRIM_HI + 10'(i), q);
    end
    apb(1'b0, 10'h030, 2'h0, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    wr(grfc_pkg::IDX_DIV, 32'h3C);
    pstrb <= 4'hE;
    wr(grfc_pkg::IDX_DIV, 32'h5A);
    pstrb <= 4'hF;
    apb(1'b1, grfc_pkg::IDX_DIV, 2'h1, 32'hAA, q, e);
    chk("misaligned err", 32'h1, {31'h0, e});
    rdc("refused writes", grfc_pkg::IDX_DIV, 32'h3C);
    for (i = 0; i < 6; i++) begin
      tr = (i == 0) ? 16'h0100 : (i == 1) ? 16'hFF00 : 16'($urandom);
      rz = (i == 0) ? 16'h7FF0 : (i == 1) ? 16'h8005 : 16'($urandom);
      wr(grfc_pkg::IDX_TRIM_HI, {24'h0, tr[15:8]});
      wr(grfc_pkg::IDX_TRIM_LO, {24'h0, tr[7:0]});
      wr(grfc_pkg::IDX_CFG, (i % 3 == 2) ? 32'h7 : $urandom & 32'h7);
      filter_bypass <= (i % 3 == 2) ? 2'h0 : 2'(i % 3 + 1);
      raw[3] <= rz;
      wstb(2, n);
      chk("z_rate_out", {16'h0, sat(rz, tr)}, {16'h0, outs[3]});
      rdc("z out reg", grfc_pkg::IDX_ZOUT, {16'h0, sat(rz, tr)});
    end
    wr(grfc_pkg::IDX_TRIM_HI, 32'h0);
    wr(grfc_pkg::IDX_TRIM_LO, 32'h0);
    filter_bypass <= 2'h1;
    raw[3] <= 16'h1000;
    wstb(2, n);
    wr(grfc_pkg::IDX_CFG, 32'h0);
    wstb(1, n);
    filter_bypass <= 2'h0;
    raw[3] <= 16'h3000;
    wstb(1, n);
    chk("filter step", 32'h2000, {16'h0, outs[3]});
    for (i = 0; i < 7; i++) begin
      wr(grfc_pkg::IDX_DIV, {24'h0, dd[i]});
      wr(grfc_pkg::IDX_CFG, {29'h0, dl[i]});
      filter_bypass <= db[i];
      wstb(2, n);
      wstb(1, n);
      chk("strobe gap", 32'(dm[i] * BC), 32'(n));
    end
    frame_sync_input <= 1'b1;
    filter_bypass <= 2'h1;
    for (p = 0; p < 8; p++) begin
      wr(grfc_pkg::IDX_CFG, 32'(p << 3));
      wstb(2, n);
      for (i = 0; i < 7; i++)
        chk("tag", 32'(raw[i] | 16'(p == i + 1)), 32'(outs[i]));
    end
    frame_sync_input <= 1'b0;
    for (p = 1; p >= 0; p--) begin
      raw[3] <= 16'h0010;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wr(grfc_pkg::IDX_CFG, 32'(p << 6));
      for (i = 0; i < 6; i++) begin
        wstb(1, n);
        raw[3] <= 16'(16 * (i + 2));
      end
      rdc("queue status", grfc_pkg::IDX_QSTAT, 32'h0001_0004);
      rdc("queue head", grfc_pkg::IDX_QDATA, p ? 32'h10 : 32'h30);
      rdc("queue next", grfc_pkg::IDX_QDATA, p ? 32'h20 : 32'h40);
    end
    test_done();
  end
endmodule // grfc_top_tb_top
`default_nettype wire
